// >>> hw/adcsc_control.sv
// Purpose: sequencing control of an 8-bit converter with 16-input mux
// Assumes: AHB-Lite single word transfers, inputs synchronous to clk
// Notes: zero wait states; the quantiser result arrives on convData
`include "adcsc_map.svh"
`timescale 1ns/100ps
`default_nettype none

module adcsc_control
    import adcsc_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // analog front end and timer
    input wire logic [7:0] convData,
    input wire logic timerSampleStrobe,
    output adcsc_analog_type analogCtrl,
    // interrupt to the core
    output logic conversionInterrupt
);

    // ****************************************************************
    // bus address phase capture
    // ****************************************************************
    logic wrPending_reg;
    logic [7:0] wrAddr_reg;
    logic addrValid;

    // a valid address phase; size is fixed to a word by the master
    assign addrValid = hsel && hready && htrans[1];

    // writes land in the data phase, so hold the address one cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wrPending_reg <= 1'b0;
            wrAddr_reg <= 8'h00;
        end else begin
            wrPending_reg <= addrValid && hwrite;
            wrAddr_reg <= haddr;
        end
    end

    // zero wait states and always OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // ****************************************************************
    // register storage
    // ****************************************************************
    adcsc_ctrl_one_type ctrlOne_reg;
    adcsc_ctrl_two_type ctrlTwo_reg;
    logic [7:0] result_reg;
    adcsc_state_type state_reg;
    logic wrOne;
    logic wrTwo;
    logic startNow;
    logic endConv;

    assign wrOne = wrPending_reg && (wrAddr_reg == `ADCSC_OFF_CTRL_ONE);
    assign wrTwo = wrPending_reg && (wrAddr_reg == `ADCSC_OFF_CTRL_TWO);

    // control one; hardware set of pending beats a software clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrlOne_reg <= `ADCSC_RST_BYTE;
        end else begin
            if (wrOne) begin
                ctrlOne_reg <= hwdata[7:0];
                if (state_reg == ST_CONVERT) begin
                    // a start bit written mid-conversion stays as it was
                    ctrlOne_reg.softwareConvertTrigger <=
                        ctrlOne_reg.softwareConvertTrigger;
                end
            end
            if (endConv) begin
                ctrlOne_reg.pending <= 1'b1;
                ctrlOne_reg.softwareConvertTrigger <= 1'b0;
            end
        end
    end

    // control two; every bit stored as written, even during a conversion
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrlTwo_reg <= `ADCSC_RST_BYTE;
        end else if (wrTwo) begin
            ctrlTwo_reg <= hwdata[7:0];
        end
    end

    // result is only loaded by the sequencer; bus writes cannot reach it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            result_reg <= `ADCSC_RST_BYTE;
        end else if (endConv) begin
            result_reg <= convData;
        end
    end

    // ****************************************************************
    // read mux, registered in the address phase
    // ****************************************************************
    function automatic logic [7:0] readMux(input logic [7:0] addr,
                                           input logic [7:0] one,
                                           input logic [7:0] two,
                                           input logic [7:0] res);
        logic [7:0] value;
        value = 8'h00;
        case (addr)
            `ADCSC_OFF_CTRL_ONE: value = one;
            `ADCSC_OFF_CTRL_TWO: value = two;
            `ADCSC_OFF_RESULT: value = res;
            default: value = 8'h00;
        endcase
        return value;
    endfunction : readMux

    // unmapped addresses read zero; upper bits always zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hrdata <= 32'h0000_0000;
        end else if (addrValid && !hwrite) begin
            hrdata <= {24'h00_0000,
                       readMux(haddr, ctrlOne_reg, ctrlTwo_reg, result_reg)};
        end
    end

    // ****************************************************************
    // start detection
    // ****************************************************************
    logic strobeLast_reg;
    logic strobeRise;
    logic swStart;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            strobeLast_reg <= 1'b0;
        end else begin
            strobeLast_reg <= timerSampleStrobe;
        end
    end

    assign strobeRise = timerSampleStrobe && !strobeLast_reg;
    // a write of one to the start bit while idle is a command
    assign swStart = wrOne && hwdata[`ADCSC_C1_START];
    // strobe only counts with auto-sampling on; software start works with it on or off
    assign startNow = (state_reg == ST_IDLE) &&
        (swStart || (ctrlTwo_reg.autoSamplingEnable && strobeRise));

    // ****************************************************************
    // conversion clock divider
    // ****************************************************************
    logic [2:0] divCnt_reg;
    logic [1:0] divSel_reg;
    logic convTick;

    // divide by 2**select, minus one as the terminal count
    function automatic logic [2:0] divLast(input logic [1:0] sel);
        logic [2:0] last;
        last = 3'h0;
        case (sel)
            2'h0: last = 3'h0;
            2'h1: last = 3'h1;
            2'h2: last = 3'h3;
            default: last = 3'h7;
        endcase
        return last;
    endfunction : divLast

    assign convTick = (state_reg == ST_CONVERT) &&
        (divCnt_reg == divLast(divSel_reg));

    // divider restarts with each conversion so the length is exact
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            divCnt_reg <= 3'h0;
        end else if (startNow || convTick) begin
            divCnt_reg <= 3'h0;
        end else if (state_reg == ST_CONVERT) begin
            divCnt_reg <= divCnt_reg + 3'h1;
        end
    end

    // ****************************************************************
    // sequencer
    // ****************************************************************
    logic [4:0] convCnt_reg;
    logic [4:0] convLast_reg;

    assign endConv = convTick && (convCnt_reg == convLast_reg);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (startNow) begin
                        state_reg <= ST_CONVERT;
                    end
                end
                ST_CONVERT: begin
                    if (endConv) begin
                        state_reg <= ST_IDLE;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // conversion clock count, cleared at trigger
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            convCnt_reg <= 5'h00;
        end else if (startNow) begin
            convCnt_reg <= 5'h00;
        end else if (convTick) begin
            convCnt_reg <= convCnt_reg + 5'h01;
        end
    end

    // settings frozen at trigger; later writes wait for the next conversion
    logic ampApplied_reg;
    logic [3:0] chanApplied_reg;
    logic refApplied_reg;
    logic uampApplied_reg;
    logic autoZeroPath;
    logic [3:0] trigChannel;

    // a start write brings its own channel; the stored one is still the old value
    assign trigChannel = swStart ? hwdata[`ADCSC_C1_CHAN_HI:`ADCSC_C1_CHAN_LO]
                                 : ctrlOne_reg.channelSelect;

    // the autozero path is the amplifier channel with the amplifier on
    assign autoZeroPath = ctrlTwo_reg.autozeroAmpEnable &&
        (trigChannel == `ADCSC_AMP_CHANNEL);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ampApplied_reg <= 1'b0;
            chanApplied_reg <= 4'h0;
            refApplied_reg <= 1'b0;
            uampApplied_reg <= 1'b0;
            divSel_reg <= 2'h0;
            convLast_reg <= `ADCSC_STD_CYCLES - 5'h01;
        end else if (startNow) begin
            ampApplied_reg <= ctrlTwo_reg.autozeroAmpEnable;
            chanApplied_reg <= trigChannel;
            refApplied_reg <= swStart ? hwdata[`ADCSC_C1_REFSEL]
                                      : ctrlOne_reg.refSelect;
            uampApplied_reg <= ctrlTwo_reg.uncommittedAmpEnable;
            divSel_reg <= ctrlTwo_reg.clockDivideSelect;
            convLast_reg <= autoZeroPath ? `ADCSC_AZ_CYCLES - 5'h01
                                         : `ADCSC_STD_CYCLES - 5'h01;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    always_comb begin
        analogCtrl.channel = chanApplied_reg;
        analogCtrl.refSelect = refApplied_reg;
        analogCtrl.autozeroAmpEnable = ampApplied_reg;
        analogCtrl.uncommittedAmpEnable = uampApplied_reg;
        // source follows the bit live; software keeps it on for its channel
        analogCtrl.currentSourceEnable = ctrlTwo_reg.currentSourceEnable;
        analogCtrl.sampleHold = (state_reg == ST_CONVERT) &&
            (convCnt_reg < `ADCSC_SAMPLE_CYCLES);
        analogCtrl.busy = (state_reg == ST_CONVERT);
    end

    // level interrupt: stays until software clears pending or the enable
    assign conversionInterrupt = ctrlOne_reg.pending && ctrlOne_reg.intEnable;

    // ****************************************************************
    // checks
    // ****************************************************************
    // eight bits: the longest conversion is 160 core cycles
    logic [7:0] cycCnt_reg;
    logic [7:0] cycWant;

    // core cycles spent in the running conversion
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cycCnt_reg <= 8'h00;
        end else if (startNow) begin
            cycCnt_reg <= 8'h00;
        end else if (state_reg == ST_CONVERT) begin
            cycCnt_reg <= cycCnt_reg + 8'h01;
        end
    end

    assign cycWant = 8'({3'h0, convLast_reg} + 8'h01) *
        8'({5'h0, divLast(divSel_reg)} + 8'h01) - 8'h01;

    sequence s_trigger;
        startNow;
    endsequence

    sequence s_sampling;
        analogCtrl.sampleHold && analogCtrl.busy;
    endsequence

    a_sample_first: assert property (@(posedge clk) disable iff (!rst_n)
        s_trigger |=> s_sampling)
        else $error("conversion did not open with sample phase");

    a_conv_length: assert property (@(posedge clk) disable iff (!rst_n)
        endConv |-> cycCnt_reg == cycWant)
        else $error("conversion length wrong");

    a_pend_on_end: assert property (@(posedge clk) disable iff (!rst_n)
        endConv |=> ctrlOne_reg.pending && !analogCtrl.busy)
        else $error("pending not set at conversion end");

    a_result_latch: assert property (@(posedge clk) disable iff (!rst_n)
        endConv |=> result_reg == $past(convData))
        else $error("result not latched");

    a_result_hold: assert property (@(posedge clk) disable iff (!rst_n)
        !endConv |=> $stable(result_reg))
        else $error("result changed outside conversion end");

    a_amp_frozen: assert property (@(posedge clk) disable iff (!rst_n)
        analogCtrl.busy && !startNow |=> $stable(ampApplied_reg))
        else $error("applied amplifier enable moved mid conversion");

    a_busy_ignores: assert property (@(posedge clk) disable iff (!rst_n)
        analogCtrl.busy && swStart && !endConv |=>
            analogCtrl.busy && convCnt_reg >= $past(convCnt_reg))
        else $error("start disturbed a running conversion");

    a_strobe_start: assert property (@(posedge clk) disable iff (!rst_n)
        !analogCtrl.busy && ctrlTwo_reg.autoSamplingEnable && strobeRise
            |=> analogCtrl.busy)
        else $error("strobe edge did not start conversion");

    a_sw_only: assert property (@(posedge clk) disable iff (!rst_n)
        !analogCtrl.busy && !ctrlTwo_reg.autoSamplingEnable && !swStart
            |=> !analogCtrl.busy)
        else $error("conversion started without software command");

    a_irq_follows: assert property (@(posedge clk) disable iff (!rst_n)
        endConv && ctrlOne_reg.intEnable && !wrOne |=> conversionInterrupt)
        else $error("interrupt missing after conversion");

endmodule : adcsc_control

`default_nettype wire

// >>> include/adcsc_map.svh
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: one aligned 32-bit word per register
// Notes: definitions only
`ifndef ADCSC_MAP_SVH
`define ADCSC_MAP_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define ADCSC_OFF_CTRL_ONE 8'h00
`define ADCSC_OFF_CTRL_TWO 8'h04
`define ADCSC_OFF_RESULT 8'h08

// ****************************************************************
// control one fields
// ****************************************************************
`define ADCSC_C1_PEND 7
`define ADCSC_C1_IEN 6
`define ADCSC_C1_START 5
`define ADCSC_C1_REFSEL 4
`define ADCSC_C1_CHAN_HI 3
`define ADCSC_C1_CHAN_LO 0

// ****************************************************************
// control two fields
// ****************************************************************
`define ADCSC_C2_AUTO 4
`define ADCSC_C2_UAMP 5
`define ADCSC_C2_DIV_HI 3
`define ADCSC_C2_DIV_LO 2
`define ADCSC_C2_ISRC 1
`define ADCSC_C2_GAIN 0

// ****************************************************************
// reset values and timing counts
// ****************************************************************
`define ADCSC_RST_BYTE 8'h00
`define ADCSC_STD_CYCLES 5'h0D
`define ADCSC_AZ_CYCLES 5'h14
`define ADCSC_SAMPLE_CYCLES 5'h03
`define ADCSC_AMP_CHANNEL 4'h0
`define ADCSC_ISRC_CHANNEL 4'h1

`endif

// >>> include/adcsc_pkg.sv
// Purpose: types shared by the converter sequencing control
// Assumes: constants live in adcsc_map.svh
// Notes: structs carry grouped fields and analog controls
`default_nettype none

package adcsc_pkg;

    // control one as software sees it
    typedef struct packed {
        logic pending;
        logic intEnable;
        logic softwareConvertTrigger;
        logic refSelect;
        logic [3:0] channelSelect;
    } adcsc_ctrl_one_type;

    // control two as software sees it
    typedef struct packed {
        logic [1:0] spare;
        logic uncommittedAmpEnable;
        logic autoSamplingEnable;
        logic [1:0] clockDivideSelect;
        logic currentSourceEnable;
        logic autozeroAmpEnable;
    } adcsc_ctrl_two_type;

    // controls applied to the analog front end
    typedef struct packed {
        logic [3:0] channel;
        logic refSelect;
        logic autozeroAmpEnable;
        logic uncommittedAmpEnable;
        logic currentSourceEnable;
        logic sampleHold;
        logic busy;
    } adcsc_analog_type;

    // sequencer states
    typedef enum logic [0:0] {
        ST_IDLE,
        ST_CONVERT
    } adcsc_state_type;

endpackage : adcsc_pkg

`default_nettype wire

// >>> test/adcsc_front_model.sv
// Purpose: stand-in for the analog front end and the timer strobe
// Assumes: the quantised value depends only on the channel held at sample time
// Notes: outside a conversion the data lines change every cycle
`timescale 1ns/100ps
`default_nettype none

module adcsc_front_model
    import adcsc_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // controls from the sequencer and the bench
    input wire adcsc_analog_type analogCtrl,
    input wire logic strobeLevel,
    // towards the sequencer
    output logic [7:0] convData,
    output logic timerSampleStrobe
);
    logic [7:0] heldValue_reg;

    // capture only while the hold switch is closed
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            heldValue_reg <= 8'h00;
        end else if (analogCtrl.sampleHold) begin
            heldValue_reg <= {4'h5, analogCtrl.channel};
        end
    end

    // idle lines toggle so a stale value never passes for a result
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            convData <= 8'hA5;
        end else begin
            convData <= analogCtrl.busy ? heldValue_reg : ~convData;
        end
    end

    // timer output follows the bench one cycle late
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            timerSampleStrobe <= 1'h0;
        end else begin
            timerSampleStrobe <= strobeLevel;
        end
    end
endmodule : adcsc_front_model

`default_nettype wire

// >>> test/test_adc_sequencing_control.sv
// Purpose: self-checking bench for the converter sequencing control
// Assumes: zero wait state slave, front end model supplies the data
// Notes: each table row is one software started conversion
`timescale 1ns/100ps
`default_nettype none
`include "adcsc_map.svh"

module test_adc_sequencing_control
    import adcsc_pkg::*;
;
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    logic hsel = 1'h0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic strobeLevel = 1'h0;
    logic hready;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic [7:0] convData;
    logic timerSampleStrobe;
    adcsc_analog_type analogCtrl;
    logic conversionInterrupt;
    int numErrors = 0;
    int comparisons = 0;
    int cycleCount = 0;
    int holdCount = 0;
    int t0 = 0;
    // control two, control one (start set), expected length in core cycles
    logic [23:0] rows [8] = '{24'h00220D, 24'h04631A, 24'h083234, 24'h0C2468,
                              24'h012014, 24'h0D60A0, 24'h01230D, 24'h22210D};

    // the single slave drives the bus ready
    assign hready = hreadyout;

    always #5 clk = ~clk;

    // cycle and hold counters for length measurements
    always @(posedge clk) begin
        cycleCount++;
        if (analogCtrl.sampleHold === 1'h1) holdCount++;
    end

    adcsc_control adcsc_control_i (
        .clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .convData(convData),
        .timerSampleStrobe(timerSampleStrobe), .analogCtrl(analogCtrl),
        .conversionInterrupt(conversionInterrupt)
    );

    adcsc_front_model adcsc_front_model_i (
        .clk(clk), .rst_n(rst_n), .analogCtrl(analogCtrl), .strobeLevel(strobeLevel),
        .convData(convData), .timerSampleStrobe(timerSampleStrobe)
    );

    // ********************
    // shared tasks
    // ********************
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
        comparisons++;
        if (seen !== exp) begin
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
            numErrors++;
        end
    endtask : check

    task automatic testDone();
        $display("comparisons %0d mismatches %0d", comparisons, numErrors);
        if (numErrors == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : testDone

    task automatic timedOut(input string what);
        $display("CHECK FAILED %s expected answer seen timeout", what);
        numErrors++;
        testDone();
    endtask : timedOut

    // one single word transfer; waits on ready in both phases
    task automatic busXfer(input logic wr, input logic [7:0] addr, input logic [7:0] wdata,
                           output logic [31:0] rdata);
        int n;
        n = 0;
        @(posedge clk);
        hsel <= 1'h1;
        haddr <= addr;
        htrans <= 2'h2;
        hwrite <= wr;
        do begin
            @(posedge clk);
            n++;
        end while (hready !== 1'h1 && n < 20);
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= {24'h0, wdata};
        do begin
            @(posedge clk);
            n++;
        end while (hready !== 1'h1 && n < 20);
        rdata = hrdata;
        #1;
        if (n >= 20) timedOut("bus answer");
    endtask : busXfer

    task automatic busWrite(input logic [7:0] addr, input logic [7:0] data);
        logic [31:0] unused;
        busXfer(1'h1, addr, data, unused);
    endtask : busWrite

    task automatic readCheck(input string what, input logic [7:0] addr, input logic [31:0] exp);
        logic [31:0] seen;
        busXfer(1'h0, addr, 8'h00, seen);
        check(what, exp, seen);
    endtask : readCheck

    task automatic startConv(input logic [7:0] one);
        busWrite(`ADCSC_OFF_CTRL_ONE, one);
        t0 = cycleCount;
        holdCount = 0;
    endtask : startConv

    // bounded waits; a long conversion is 160 cycles
    task automatic waitBusy(input logic level);
        int n;
        n = 0;
        while (analogCtrl.busy !== level && n < 400) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n >= 400) timedOut("busy change");
    endtask : waitBusy

    // strobe level is held long enough for any trigger to show
    task automatic setStrobe(input logic level);
        @(posedge clk);
        strobeLevel <= level;
        repeat (4) @(posedge clk);
        #1;
    endtask : setStrobe

    // ********************
    // main sequence
    // ********************
    initial begin : mainSequence
        int expCycles;
        logic [7:0] one;
        logic [7:0] two;
        repeat (2) @(posedge clk);
        rst_n <= 1'h1;
        #1;
        check("front end idle", 32'h0, analogCtrl);
        check("interrupt idle", 32'h0, conversionInterrupt);
        check("bus ready", 32'h1, hreadyout);
        check("bus response", 32'h0, hresp);
        readCheck("control one", `ADCSC_OFF_CTRL_ONE, 32'h0);
        readCheck("control two", `ADCSC_OFF_CTRL_TWO, 32'h0);
        readCheck("result", `ADCSC_OFF_RESULT, 32'h0);
        $display("test reset values done");
        // every divider, standard and autozero length
        foreach (rows[i]) begin
            two = rows[i][23:16];
            one = rows[i][15:8];
            expCycles = rows[i][7:0];
            busWrite(`ADCSC_OFF_CTRL_TWO, two);
            check("source enable", two[1], analogCtrl.currentSourceEnable);
            startConv(one);
            check("busy", 32'h1, analogCtrl.busy);
            check("channel", one[3:0], analogCtrl.channel);
            check("reference", one[4], analogCtrl.refSelect);
            check("gain applied", two[0], analogCtrl.autozeroAmpEnable);
            check("uncommitted amp", two[5], analogCtrl.uncommittedAmpEnable);
            waitBusy(1'h0);
            check("length", expCycles, cycleCount - t0);
            check("hold length", 3 << two[3:2], holdCount);
            readCheck("result", `ADCSC_OFF_RESULT, {4'h5, one[3:0]});
            readCheck("pending", `ADCSC_OFF_CTRL_ONE, {1'h1, one[6], 1'h0, one[4:0]});
            check("interrupt", one[6], conversionInterrupt);
            busWrite(`ADCSC_OFF_CTRL_ONE, 8'h00);
            check("interrupt cleared", 32'h0, conversionInterrupt);
        end
        $display("test conversion table done");
        // register access, result write and unmapped place
        busWrite(`ADCSC_OFF_CTRL_ONE, 8'hD3);
        readCheck("control one rw", `ADCSC_OFF_CTRL_ONE, 32'hD3);
        check("interrupt on pending", 32'h1, conversionInterrupt);
        busWrite(`ADCSC_OFF_CTRL_TWO, 8'hE3);
        readCheck("control two rw", `ADCSC_OFF_CTRL_TWO, 32'hE3);
        busWrite(`ADCSC_OFF_RESULT, 8'hFF);
        readCheck("result read only", `ADCSC_OFF_RESULT, 32'h51);
        readCheck("unmapped", 8'h0C, 32'h0);
        busWrite(`ADCSC_OFF_CTRL_ONE, 8'h00);
        $display("test register access done");
        // applied gain frozen, second start ignored
        busWrite(`ADCSC_OFF_CTRL_TWO, 8'h0D);
        startConv(8'h20);
        busWrite(`ADCSC_OFF_CTRL_TWO, 8'h0C);
        readCheck("gain readback", `ADCSC_OFF_CTRL_TWO, 32'h0C);
        check("gain frozen", 32'h1, analogCtrl.autozeroAmpEnable);
        busWrite(`ADCSC_OFF_CTRL_ONE, 8'h24);
        check("channel kept", 32'h0, analogCtrl.channel);
        waitBusy(1'h0);
        check("undisturbed length", `ADCSC_AZ_CYCLES * 8, cycleCount - t0);
        readCheck("undisturbed result", `ADCSC_OFF_RESULT, 32'h50);
        busWrite(`ADCSC_OFF_CTRL_ONE, 8'h00);
        $display("test busy writes done");
        // timer strobe with auto sampling off, then on
        setStrobe(1'h1);
        check("no auto start", 32'h0, analogCtrl.busy);
        setStrobe(1'h0);
        busWrite(`ADCSC_OFF_CTRL_ONE, 8'h03);
        busWrite(`ADCSC_OFF_CTRL_TWO, 8'h08);
        busWrite(`ADCSC_OFF_CTRL_TWO, 8'h18);
        @(posedge clk);
        strobeLevel <= 1'h1;
        waitBusy(1'h1);
        t0 = cycleCount;
        waitBusy(1'h0);
        check("strobe length", `ADCSC_STD_CYCLES * 4, cycleCount - t0);
        setStrobe(1'h1);
        check("level no retrigger", 32'h0, analogCtrl.busy);
        readCheck("strobe result", `ADCSC_OFF_RESULT, 32'h53);
        setStrobe(1'h0);
        busWrite(`ADCSC_OFF_CTRL_TWO, 8'h00);
        $display("test auto sampling done");
        // reset in the middle of a conversion
        startConv(8'h22);
        repeat (3) @(posedge clk);
        rst_n <= 1'h0;
        #1;
        check("reset front end", 32'h0, analogCtrl);
        @(posedge clk);
        rst_n <= 1'h1;
        readCheck("reset control one", `ADCSC_OFF_CTRL_ONE, 32'h0);
        $display("test mid-run reset done");
        testDone();
    end
endmodule : test_adc_sequencing_control

`default_nettype wire
